// ### aotc_defs.vh
/*
 * constants for the analog output timing control block:
 * source selects, field widths, reset values and timing counts.
 * assumes inclusion by bare name from the design files.
 */
`ifndef AOTC_DEFS_VH
`define AOTC_DEFS_VH

// ****************************************
// widths
// ****************************************
`define AOTC_NUM_PINS        8
`define AOTC_NUM_INT         4
`define AOTC_SEL_W           4
`define AOTC_DIV_W           16
`define AOTC_DLY_W           16
`define AOTC_NUM_CH          16

// ****************************************
// start trigger source codes
// ****************************************
`define AOTC_STRT_NONE       4'h0
`define AOTC_STRT_SW         4'h1
`define AOTC_STRT_PIN        4'h2
`define AOTC_STRT_ACQREF     4'h3
`define AOTC_STRT_ACQSTART   4'h4
`define AOTC_STRT_INT        4'h5
`define AOTC_STRT_ANALOG     4'h6

// ****************************************
// pause trigger source codes
// ****************************************
`define AOTC_PSE_NONE        4'h0
`define AOTC_PSE_PIN         4'h1
`define AOTC_PSE_INT         4'h2
`define AOTC_PSE_ANALOG      4'h3

// ****************************************
// reset values and timing
// ****************************************
`define AOTC_DIV_RST         16'h0001
`define AOTC_DLY_RST         16'h0000
`define AOTC_START_PULSE_NS  8
`define AOTC_CLK_NS          4
`define AOTC_START_PULSE_CYC ((`AOTC_START_PULSE_NS + `AOTC_CLK_NS - 1) / `AOTC_CLK_NS)

`endif

// ### aotc_src_model.sv
/* far-side model: function pins, acquisition triggers, analog event,
   external tick and timebase. assumes setLvl calls after a clock edge. */
`timescale 1ns/1ps
module aotc_src_model (
  output logic [7:0] pinIn,
  output logic       extTimebase,
  output logic       extTick,
  output logic       analogEvent,
  output logic       acqRefTrig,
  output logic       acqStartTrig,
  input  wire logic  tickEn
);
  initial begin
    {pinIn, extTimebase, extTick, analogEvent, acqRefTrig, acqStartTrig} = 13'h0000;
  end
  // tick stands low while tickEn is low, phase unrelated to clk_sys
  always #7 extTick = tickEn ? ~extTick : 1'b0;
  always #3 extTimebase = ~extTimebase;
  // analog event moves on any setLvl call with an index above 9
  task automatic setLvl(input int idx, input logic v);
    if (idx < 8) pinIn[idx] = v;
    else if (idx == 8) acqRefTrig = v;
    else if (idx == 9) acqStartTrig = v;
    else analogEvent = v;
  endtask
endmodule

// ### aotc_sync2.v
/*
 * two flip-flop synchroniser for a bundle of asynchronous levels.
 * assumes inputs come from pins or another clock; output is clk_sys level.
 */
`timescale 1ns/1ps

module aotc_sync2 #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire         nrst,
  input  wire [W-1:0] asyncIn,
  output reg  [W-1:0] syncOut
);

  reg [W-1:0] meta_r;

  // only the second stage reads the first
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_r  <= {W{1'b0}};
      syncOut <= {W{1'b0}};
    end else begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule

// ### aotc_timing_ctrl.v
/*
 * analog output timing control: sample tick from a divided timebase,
 * start trigger with edge select and delay (internal tick only), pause trigger with level
 * select, and routing of tick and start pulse onto function pins.
 * assumes config ports are quasi-static, from logic on clk_sys;
 * pins, analog event and external timebase/tick are asynchronous.
 */
`timescale 1ns/1ps
`include "aotc_defs.vh"

module aotc_timing_ctrl (
  input  wire                       clk_sys,
  input  wire                       nrst,
  input  wire [`AOTC_NUM_PINS-1:0]  pinIn,
  input  wire                       extTimebase,
  input  wire                       extTick,
  input  wire                       analogEvent,
  input  wire                       acqRefTrig,
  input  wire                       acqStartTrig,
  input  wire [`AOTC_NUM_INT-1:0]   intSignals,
  input  wire                       intTimebaseEn,
  input  wire                       swStartPulse,
  input  wire                       swStop,
  input  wire                       tickSrcExt,
  input  wire                       tbSrcExt,
  input  wire [`AOTC_DIV_W-1:0]     tickDivisor,
  input  wire [`AOTC_DLY_W-1:0]     startDelay,
  input  wire [`AOTC_SEL_W-1:0]     startSrcSel,
  input  wire [2:0]                 startPinSel,
  input  wire [1:0]                 startIntSel,
  input  wire                       startFalling,
  input  wire [`AOTC_SEL_W-1:0]     pauseSrcSel,
  input  wire [2:0]                 pausePinSel,
  input  wire [1:0]                 pauseIntSel,
  input  wire                       pauseActiveLow,
  input  wire [`AOTC_NUM_CH-1:0]    chanInTask,
  input  wire [`AOTC_NUM_PINS-1:0]  pinIsOutput,
  input  wire [`AOTC_NUM_PINS-1:0]  pinRouteTick,
  input  wire [`AOTC_NUM_PINS-1:0]  pinRouteStart,
  output reg  [`AOTC_NUM_CH-1:0]    chanUpdate,
  output reg                        outSampleTick,
  output reg                        running,
  output reg                        paused,
  output reg  [`AOTC_NUM_PINS-1:0]  pinOut,
  output reg  [`AOTC_NUM_PINS-1:0]  pinOe
);

  // ****************************************
  // state encoding
  // ****************************************
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_ARMED = 4'b0010;
  localparam [3:0] ST_DELAY = 4'b0100;
  localparam [3:0] ST_RUN   = 4'b1000;

  localparam integer PULSE_CYC_I = `AOTC_START_PULSE_CYC;
  localparam [1:0]   PULSE_CYC   = PULSE_CYC_I[1:0];

  // ****************************************
  // synchronisers
  // ****************************************
  wire [`AOTC_NUM_PINS+4:0] asyncBus;
  wire [`AOTC_NUM_PINS+4:0] syncBus;

  assign asyncBus = {acqStartTrig, acqRefTrig, analogEvent, extTick, extTimebase, pinIn};

  aotc_sync2 #(
    .W(`AOTC_NUM_PINS + 5)
  ) uSync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .asyncIn (asyncBus),
    .syncOut (syncBus)
  );

  wire [`AOTC_NUM_PINS-1:0] pinS;
  wire                      tbS;
  wire                      tickS;
  wire                      anaS;
  wire                      refS;
  wire                      acqS;

  assign pinS = syncBus[`AOTC_NUM_PINS-1:0];
  assign tbS  = syncBus[`AOTC_NUM_PINS];
  assign tickS = syncBus[`AOTC_NUM_PINS+1];
  assign anaS = syncBus[`AOTC_NUM_PINS+2];
  assign refS = syncBus[`AOTC_NUM_PINS+3];
  assign acqS = syncBus[`AOTC_NUM_PINS+4];

  // ****************************************
  // edge history
  // ****************************************
  reg tbPrev_r;
  reg tickPrev_r;
  reg startLvlPrev_r;
  reg pauseAct_r;

  function rise;
    input cur;
    input prev;
    begin
      rise = cur & ~prev;
    end
  endfunction

  // ****************************************
  // trigger selection
  // ****************************************
  reg startLvl;
  reg startLvlPol;
  reg pauseLvl;
  reg pauseAct;

  always @* begin
    startLvl = 1'b0;
    if (startSrcSel == `AOTC_STRT_PIN) begin
      startLvl = pinS[startPinSel];
    end else if (startSrcSel == `AOTC_STRT_ACQREF) begin
      startLvl = refS;
    end else if (startSrcSel == `AOTC_STRT_ACQSTART) begin
      startLvl = acqS;
    end else if (startSrcSel == `AOTC_STRT_INT) begin
      startLvl = intSignals[startIntSel];
    end else if (startSrcSel == `AOTC_STRT_ANALOG) begin
      startLvl = anaS;
    end
    startLvlPol = startLvl ^ startFalling;
  end

  always @* begin
    pauseLvl = 1'b0;
    if (pauseSrcSel == `AOTC_PSE_PIN) begin
      pauseLvl = pinS[pausePinSel];
    end else if (pauseSrcSel == `AOTC_PSE_INT) begin
      pauseLvl = intSignals[pauseIntSel];
    end else if (pauseSrcSel == `AOTC_PSE_ANALOG) begin
      pauseLvl = anaS;
    end
    // none selected never pauses, whatever the polarity
    pauseAct = (pauseSrcSel != `AOTC_PSE_NONE) && (pauseLvl ^ pauseActiveLow);
  end

  // software pulse counts as trigger when chosen, or when no trigger is set
  wire swSel      = (startSrcSel == `AOTC_STRT_SW) || (startSrcSel == `AOTC_STRT_NONE);
  wire startEvent = swSel ? swStartPulse : rise(startLvlPol, startLvlPrev_r);

  // ****************************************
  // timebase and divider
  // ****************************************
  reg  [`AOTC_DIV_W-1:0] divCnt_r;
  wire tbEdge  = tbSrcExt ? rise(tbS, tbPrev_r) : intTimebaseEn;
  wire extEdge = rise(tickS, tickPrev_r);
  wire [`AOTC_DIV_W-1:0] divLast = (tickDivisor == {`AOTC_DIV_W{1'b0}}) ?
                                   {`AOTC_DIV_W{1'b0}} : tickDivisor - 1'b1;
  wire divHit  = tbEdge && (divCnt_r >= divLast);

  // ****************************************
  // control state
  // ****************************************
  reg [3:0]             state_r;
  reg [3:0]             state_nxt;
  reg [`AOTC_DLY_W-1:0] dlyCnt_r;
  reg                   waitTick_r;
  reg [1:0]             strtPulseCnt_r;

  wire rawTick = tickSrcExt ? extEdge : divHit;
  // pause is sampled at the tick boundary, so a running sample finishes
  wire tickOk  = rawTick && !pauseAct && !waitTick_r;
  // a stop in the same cycle wins, so no tick trails the run
  wire tickGo  = tickOk && (state_r == ST_RUN) && !swStop;
  wire dlyLast = (dlyCnt_r == {{(`AOTC_DLY_W-1){1'b0}}, 1'b1});

  // delay only with the internal tick; zero means none
  function useDelay;
    input                   extSel;
    input [`AOTC_DLY_W-1:0] dly;
    begin
      useDelay = !extSel && (dly != {`AOTC_DLY_W{1'b0}});
    end
  endfunction

  // gate a route mask with one level
  function [`AOTC_NUM_PINS-1:0] fillPins;
    input [`AOTC_NUM_PINS-1:0] route;
    input                      lvl;
    begin
      fillPins = route & {`AOTC_NUM_PINS{lvl}};
    end
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (startEvent) begin
          state_nxt = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (useDelay(tickSrcExt, startDelay)) begin
          state_nxt = ST_DELAY;
        end else begin
          state_nxt = ST_RUN;
        end
      end
      ST_DELAY: begin
        if (tbEdge && dlyLast) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // stop is honoured in every state
    if (swStop) begin
      state_nxt = ST_IDLE;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // edge history and pause wait
  // ****************************************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tbPrev_r       <= 1'b0;
      tickPrev_r     <= 1'b0;
      startLvlPrev_r <= 1'b0;
      pauseAct_r     <= 1'b0;
    end else begin
      tbPrev_r       <= tbS;
      tickPrev_r     <= tickS;
      startLvlPrev_r <= startLvlPol;
      pauseAct_r     <= pauseAct;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      waitTick_r <= 1'b0;
    end else if (swStop || state_r != ST_RUN) begin
      waitTick_r <= 1'b0;
    end else if (pauseAct && !pauseAct_r && tickSrcExt) begin
      waitTick_r <= 1'b1;
    end else if (waitTick_r && !pauseAct && rawTick) begin
      waitTick_r <= 1'b0;
    end
  end

  // ****************************************
  // divider and start delay
  // ****************************************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      divCnt_r <= {`AOTC_DIV_W{1'b0}};
      dlyCnt_r <= {`AOTC_DLY_W{1'b0}};
    end else if (state_r == ST_ARMED) begin
      divCnt_r <= {`AOTC_DIV_W{1'b0}};
      dlyCnt_r <= startDelay;
    end else if (state_r == ST_DELAY && tbEdge) begin
      dlyCnt_r <= dlyCnt_r - 1'b1;
    end else if (state_r == ST_RUN && tbEdge) begin
      // divider runs only while generating so the first sample is aligned
      divCnt_r <= divHit ? {`AOTC_DIV_W{1'b0}} : divCnt_r + 1'b1;
    end
  end

  // ****************************************
  // start pulse width
  // ****************************************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      strtPulseCnt_r <= 2'h0;
    end else if (state_r == ST_ARMED) begin
      strtPulseCnt_r <= PULSE_CYC;
    end else if (strtPulseCnt_r != 2'h0) begin
      strtPulseCnt_r <= strtPulseCnt_r - 2'h1;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      outSampleTick <= 1'b0;
      chanUpdate    <= {`AOTC_NUM_CH{1'b0}};
      running       <= 1'b0;
      paused        <= 1'b0;
      pinOut        <= {`AOTC_NUM_PINS{1'b0}};
      pinOe         <= {`AOTC_NUM_PINS{1'b0}};
    end else begin
      outSampleTick <= tickGo;
      chanUpdate    <= tickGo ? chanInTask : {`AOTC_NUM_CH{1'b0}};
      running       <= (state_r == ST_RUN) && !swStop;
      // onboard tick: paused flag follows trigger directly
      paused        <= (state_r == ST_RUN) && (pauseAct || waitTick_r);
      // timebase has no pin route at all
      pinOe         <= pinIsOutput & (pinRouteTick | pinRouteStart);
      pinOut        <= pinIsOutput & (fillPins(pinRouteTick, tickGo) |
                       fillPins(pinRouteStart, strtPulseCnt_r != 2'h0));
    end
  end

endmodule

// ### aotc_timing_ctrl_asserts.sv
/* checker for the timing control ports.
   assumes a bind from the bench top; one clock, async low reset. */
`timescale 1ns/1ps
`include "aotc_defs.vh"
module aotc_timing_ctrl_asserts (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        swStartPulse,
  input wire logic        swStop,
  input wire logic [3:0]  startSrcSel,
  input wire logic        tickSrcExt,
  input wire logic [15:0] tickDivisor,
  input wire logic [15:0] chanInTask,
  input wire logic [7:0]  pinIsOutput,
  input wire logic [15:0] chanUpdate,
  input wire logic        outSampleTick,
  input wire logic        running,
  input wire logic        paused,
  input wire logic [7:0]  pinOut,
  input wire logic [7:0]  pinOe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ****************************************
  // tick gap counter, saturates on long idle
  // ****************************************
  logic [16:0] gap_r;
  logic        seen_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gap_r  <= 17'h00000;
      seen_r <= 1'b0;
    end else if (outSampleTick) begin
      gap_r  <= 17'h00001;
      seen_r <= 1'b1;
    end else if (gap_r != 17'h1FFFF) begin
      gap_r <= gap_r + 17'h00001;
    end
  end
  chk_upd_mask: assert property (outSampleTick |-> chanUpdate == chanInTask)
    else $error("update mask wrong");
  chk_upd_quiet: assert property (!outSampleTick |-> chanUpdate == 16'h0000)
    else $error("update without tick");
  chk_tick_held: assert property ($past(paused) && paused |-> !outSampleTick)
    else $error("tick while paused");
  chk_tick_run: assert property (outSampleTick |-> ##[0:1] running)
    else $error("tick while idle");
  chk_oe_output: assert property ((pinOe & ~pinIsOutput) == 8'h00)
    else $error("drive on input pin");
  chk_start_pulse: assert property ($rose(pinOut[1]) |-> pinOut[1] [*2] ##1 !pinOut[1])
    else $error("start pulse width");
  chk_tick_gap: assert property (outSampleTick && seen_r && !tickSrcExt
    |-> gap_r >= {1'b0, tickDivisor})
    else $error("tick gap short");
  chk_start_lat: assert property (!running && swStartPulse && !swStop
    && startSrcSel == `AOTC_STRT_SW |-> ##3 running)
    else $error("start latency");
  cov_start: cover property (swStartPulse ##3 running);
  cov_pause: cover property ($rose(paused));
  cov_ext: cover property (outSampleTick && tickSrcExt);
endmodule

// ### aotc_timing_ctrl_tb_top.sv
/* bench: drives config and starts, scores ticks against queued notes.
   assumes the checker and source model compile first. */
`timescale 1ns/1ps
`include "aotc_defs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module aotc_timing_ctrl_tb_top;
  logic        clk_sys, nrst, intTimebaseEn, swStartPulse, swStop, tickSrcExt, tbSrcExt;
  logic        startFalling, pauseActiveLow, tickEn;
  logic [3:0]  intSignals, startSrcSel, pauseSrcSel;
  logic [2:0]  startPinSel, pausePinSel;
  logic [1:0]  startIntSel, pauseIntSel;
  logic [15:0] tickDivisor, startDelay, chanInTask, expUpd;
  logic [7:0]  pinIsOutput, pinRouteTick, pinRouteStart;
  wire  [7:0]  pinIn, pinOut, pinOe;
  wire  [15:0] chanUpdate;
  wire         extTimebase, extTick, analogEvent, acqRefTrig, acqStartTrig;
  wire         outSampleTick, running, paused;
  logic [15:0] notes[$];
  int          failures = 0, samples_checked = 0, k, i;
  int          srcIdx[5] = '{3, 8, 9, 11, 10};
  aotc_src_model u_aotc_src_model (.pinIn, .extTimebase, .extTick, .analogEvent,
    .acqRefTrig, .acqStartTrig, .tickEn);
  aotc_timing_ctrl u_aotc_timing_ctrl (.clk_sys, .nrst, .pinIn, .extTimebase, .extTick,
    .analogEvent, .acqRefTrig, .acqStartTrig, .intSignals, .intTimebaseEn, .swStartPulse,
    .swStop, .tickSrcExt, .tbSrcExt, .tickDivisor, .startDelay, .startSrcSel, .startPinSel,
    .startIntSel, .startFalling, .pauseSrcSel, .pausePinSel, .pauseIntSel, .pauseActiveLow,
    .chanInTask, .pinIsOutput, .pinRouteTick, .pinRouteStart, .chanUpdate, .outSampleTick,
    .running, .paused, .pinOut, .pinOe);
  // ****************************************
  // clock, random timebase, tick scoreboard
  // ****************************************
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    #1 intTimebaseEn = 1'($urandom);
  end
  always @(posedge clk_sys) begin
    if (nrst === 1'b1 && outSampleTick === 1'b1) begin
      `CHK(notes.size() != 0, 1'b1)
      if (notes.size() != 0) begin
        expUpd = notes.pop_front();
        `CHK(chanUpdate, expUpd)
      end
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic lvl(input int idx, input logic v);
    if (idx > 10) intSignals[idx - 10] = v;
    else u_aotc_src_model.setLvl(idx, v);
  endtask
  // slack of 8 notes absorbs ticks landing while a stop or pause settles
  task automatic arm(input int n);
    repeat (n + 8) notes.push_back(chanInTask);
  endtask
  task automatic await_ticks();
    for (i = 0; i < 3000 && notes.size() > 8; i++) cyc(1);
    `CHK(notes.size() <= 8, 1'b1)
  endtask
  task automatic sw_start();
    startSrcSel = `AOTC_STRT_SW;
    startDelay = 16'h0000;
    swStartPulse = 1'b1;
    cyc(1);
    swStartPulse = 1'b0;
    cyc(3);
    `CHK(running, 1'b1)
  endtask
  task automatic stop_run();
    swStop = 1'b1;
    cyc(1);
    swStop = 1'b0;
    cyc(2);
    `CHK(running, 1'b0)
    notes.delete();
  endtask
  task automatic pause_check(input int idx, input logic act);
    lvl(idx, act);
    cyc(8);
    `CHK(paused, 1'b1)
    notes.delete();
    cyc(40);
    arm(3);
    lvl(idx, !act);
    await_ticks();
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    close_out();
  end
  initial begin
    {clk_sys, nrst, intTimebaseEn, swStartPulse, swStop, tickSrcExt, tbSrcExt} = 7'h00;
    {startFalling, pauseActiveLow, tickEn, intSignals} = 7'h00;
    {startSrcSel, pauseSrcSel, startPinSel, pausePinSel, startIntSel, pauseIntSel} =
      {4'h0, 4'h0, 3'h3, 3'h2, 2'h1, 2'h2};
    {tickDivisor, startDelay, chanInTask} = 48'h0001_0000_0000;
    {pinIsOutput, pinRouteTick, pinRouteStart} = 24'h03_01_02;
    void'($urandom(32'hF620));
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1'b1;
    cyc(2);
    tickDivisor = 16'h0001 + 16'($urandom % 16);
    chanInTask = 16'($urandom);
    pauseSrcSel = `AOTC_PSE_PIN;
    pauseActiveLow = 1'($urandom);
    lvl(2, pauseActiveLow);
    arm(4);
    sw_start();
    await_ticks();
    pause_check(2, !pauseActiveLow);
    stop_run();
    pauseSrcSel = `AOTC_PSE_NONE;
    for (k = 0; k < 5; k++) begin
      startSrcSel = `AOTC_STRT_NONE;
      startFalling = 1'($urandom);
      lvl(srcIdx[k], startFalling);
      cyc(4);
      startSrcSel = `AOTC_STRT_PIN + 4'(k);
      startDelay = 16'($urandom % 16);
      {tbSrcExt, tickSrcExt, tickEn} = {k[1], k[0], k[0]};
      tickDivisor = 16'h0001 + 16'($urandom % 4);
      chanInTask = 16'($urandom);
      cyc(10);
      `CHK(running, 1'b0)
      arm(2);
      lvl(srcIdx[k], !startFalling);
      for (i = 0; i < 200 && running !== 1'b1; i++) cyc(1);
      `CHK(running, 1'b1)
      await_ticks();
      stop_run();
      lvl(srcIdx[k], startFalling);
    end
    {tbSrcExt, tickSrcExt, tickEn} = 3'b011;
    pauseActiveLow = 1'b0;
    for (k = 0; k < 2; k++) begin
      pauseSrcSel = k ? `AOTC_PSE_ANALOG : `AOTC_PSE_INT;
      arm(2);
      sw_start();
      await_ticks();
      pause_check(k ? 10 : 12, 1'b1);
      stop_run();
    end
    close_out();
  end
endmodule
bind aotc_timing_ctrl aotc_timing_ctrl_asserts u_aotc_timing_ctrl_asserts (.clk_sys, .nrst,
  .swStartPulse, .swStop, .startSrcSel, .tickSrcExt, .tickDivisor, .chanInTask, .pinIsOutput,
  .chanUpdate, .outSampleTick, .running, .paused, .pinOut, .pinOe);
